// File: rtl/sensor_spi_map.svh
// widths, field positions, reset values and timing counts of the sensor spi port
`ifndef SENSOR_SPI_MAP_SVH
`define SENSOR_SPI_MAP_SVH

`define FRAME_BITS        32
`define CNT_W             6
`define WORD_W            16
`define RESP_DATA_HI      31
`define RESP_ECHO_HI      15
`define RESP_ECHO_LO      8
`define RESP_READY_BIT    7
`define GYRO_SENS_LSB_DPS 50
`define GYRO_FS_DPS       655
`define SCLK_MAX_KHZ      8000
`define REF_CLK_MHZ       25
`define STARTUP_TIME_US   250000
`define STARTUP_CYCLES    (`STARTUP_TIME_US * `REF_CLK_MHZ)
`define BOOT_CNT_W        23
`define CS_IDLE           1'b1

`endif

// File: rtl/sensor_spi_pkg.sv
// types shared by the sensor spi port
package sensor_spi_pkg;

	typedef enum logic [0:0] {
		ST_BOOT,
		ST_RUN
	} boot_state_e;

	typedef struct packed {
		logic [5:0]  cnt;
		logic [31:0] rx;
	} rise_state_s;

	typedef struct packed {
		logic [31:0] tx;
		logic        miso;
		logic [31:0] cmd;
	} fall_state_s;

	typedef struct packed {
		boot_state_e st;
		logic [22:0] boot_cnt;
		logic        cs_prev;
		logic [15:0] data;
		logic        rdy;
		logic        oe;
		logic [31:0] cmd;
		logic        cmd_vld;
	} ref_state_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} sync_state_s;

endpackage : sensor_spi_pkg

// File: rtl/sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module sync3 #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic d_i,
	output logic      q_o
);
	sensor_spi_pkg::sync_state_s s_r;
	sensor_spi_pkg::sync_state_s s_nxt;

	always_comb
	begin
		s_nxt    = s_r;
		s_nxt.s1 = d_i;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		// first stage is only read by the second
		if (s_r.s2 == s_r.s3)
		begin
			s_nxt.q = s_r.s3;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign q_o = s_r.q;
endmodule : sync3

// File: rtl/inertial_sensor_spi_slave.sv
// slave spi port of the inertial sensor with startup self-test gating
//
// Notes on behaviour
// - slave only; never drives clock or select
// - four wires, serial clock up to 8 MHz
// - data out released while select is high
// - words shift msb first, lsb last
// - incoming bits sampled on rising clock edge
// - outgoing bits change on falling clock edge
// - sensor words are 16-bit two's complement
// - default rate scale 50 codes per dps
// - outputs valid only after startup self-test
// - a transfer is exactly 32 clocks
// - response returned in the following frame
// - internal data updates at select rising edge
`timescale 1ns/1ps
`include "sensor_spi_map.svh"
module inertial_sensor_spi_slave #(
	parameter int STARTUP_CYCLES = `STARTUP_CYCLES
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        sclk_i,
	input  wire logic        chip_select_n_i,
	input  wire logic        mosi_i,
	input  wire logic [15:0] sample_i,
	output logic             miso_o,
	output logic             miso_oe_o,
	output logic             startup_done_o,
	output logic [31:0]      cmd_o,
	output logic             cmd_valid_o
);
	localparam logic [5:0]  FRAME_LEN = 6'(`FRAME_BITS);
	localparam logic [22:0] BOOT_LAST = 23'(STARTUP_CYCLES - 1);

	sensor_spi_pkg::rise_state_s rise_r;
	sensor_spi_pkg::rise_state_s rise_nxt;
	sensor_spi_pkg::fall_state_s fall_r;
	sensor_spi_pkg::fall_state_s fall_nxt;
	sensor_spi_pkg::ref_state_s  ref_r;
	sensor_spi_pkg::ref_state_s  ref_nxt;
	logic                        link_rstn;
	logic                        cs_n_sync;
	logic [31:0]                 resp;

	////////////////////////////////////////////////////////////////////////////
	// link side, rising edge: bit counter and receive shifter

	// select high holds the rising-edge link logic in reset: stray clocks do nothing
	assign link_rstn = rstn_i & ~chip_select_n_i;

	always_comb
	begin
		rise_nxt = rise_r;
		// extra clocks past the frame length are ignored
		if (rise_r.cnt < FRAME_LEN)
		begin
			rise_nxt.cnt = rise_r.cnt + 6'h01;
			rise_nxt.rx  = {rise_r.rx[30:0], mosi_i};
		end
	end

	always_ff @(posedge sclk_i or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			rise_r <= '0;
		end
		else
		begin
			rise_r <= rise_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link side, falling edge: transmit shifter

	// ref-side data and ready only move while select is high, so they are static here
	always_comb
	begin
		resp = 32'h0000_0000;
		if (ref_r.rdy)
		begin
			resp[`RESP_DATA_HI -: `WORD_W] = ref_r.data;
		end
		resp[`RESP_ECHO_HI:`RESP_ECHO_LO] = rise_r.rx[`RESP_ECHO_HI:`RESP_ECHO_LO];
		resp[`RESP_READY_BIT]             = ref_r.rdy;
	end

	always_comb
	begin
		fall_nxt = fall_r;
		if (rise_r.cnt == FRAME_LEN)
		begin
			// last falling edge preloads the answer for the next frame
			fall_nxt.miso = resp[31];
			fall_nxt.tx   = {resp[30:0], 1'b0};
			fall_nxt.cmd  = rise_r.rx;
		end
		else if (rise_r.cnt != 6'h00)
		begin
			fall_nxt.miso = fall_r.tx[31];
			fall_nxt.tx   = {fall_r.tx[30:0], 1'b0};
		end
	end

	always_ff @(negedge sclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			fall_r <= '0;
		end
		else
		begin
			fall_r <= fall_nxt;
		end
	end

	assign miso_o = fall_r.miso;

	////////////////////////////////////////////////////////////////////////////
	// reference side: select tracking, startup timer, frame-end update

	sync3 #(
		.RST_VAL (`CS_IDLE)
	) u_cs_sync (
		.clk_i  (ref_clk_i),
		.rstn_i (rstn_i),
		.d_i    (chip_select_n_i),
		.q_o    (cs_n_sync)
	);

	always_comb
	begin
		ref_nxt         = ref_r;
		ref_nxt.cs_prev = cs_n_sync;
		ref_nxt.cmd_vld = 1'b0;
		// enable lags select by the synchroniser depth plus one register
		ref_nxt.oe      = ~cs_n_sync;
		case (ref_r.st)
			sensor_spi_pkg::ST_BOOT:
			begin
				ref_nxt.boot_cnt = ref_r.boot_cnt + 23'h000001;
				if (ref_r.boot_cnt >= BOOT_LAST)
				begin
					ref_nxt.st = sensor_spi_pkg::ST_RUN;
				end
			end
			sensor_spi_pkg::ST_RUN:
			begin
				ref_nxt.boot_cnt = ref_r.boot_cnt;
			end
			default:
			begin
				ref_nxt.st = sensor_spi_pkg::ST_BOOT;
			end
		endcase
		if (cs_n_sync && !ref_r.cs_prev)
		begin
			// frame end: refresh the data served in the frame after next
			ref_nxt.rdy     = (ref_r.st == sensor_spi_pkg::ST_RUN);
			ref_nxt.data    = sample_i;
			ref_nxt.cmd     = fall_r.cmd;
			ref_nxt.cmd_vld = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ref_r <= '{st: sensor_spi_pkg::ST_BOOT, boot_cnt: 23'h000000, cs_prev: `CS_IDLE,
				data: 16'h0000, rdy: 1'b0, oe: 1'b0, cmd: 32'h0000_0000, cmd_vld: 1'b0};
		end
		else
		begin
			ref_r <= ref_nxt;
		end
	end

	assign miso_oe_o      = ref_r.oe;
	assign startup_done_o = ref_r.rdy;
	assign cmd_o          = ref_r.cmd;
	assign cmd_valid_o    = ref_r.cmd_vld;
endmodule : inertial_sensor_spi_slave

// File: test/spi_host.sv
// host spi master model for the sensor port
`timescale 1ns/1ps
module spi_host (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// clock stands low outside frames; 160 ns period
	task automatic xfer(input logic [31:0] w, output logic [31:0] r);
		#7 cs_n_o = 1'b0;
		#200;
		for (int i = 31; i >= 0; i--)
		begin
			mosi_o = w[i];
			#80 sclk_o = 1'b1;
			r[i] = miso_i;
			#80 sclk_o = 1'b0;
		end
		mosi_o = ~mosi_o;
		#40 cs_n_o = 1'b1;
		#300;
	endtask : xfer
endmodule : spi_host

// File: test/spi_slave_assertions.sv
// property checks for the sensor spi slave port
`timescale 1ns/1ps
module spi_slave_checks #(
	parameter int STARTUP_CYCLES = 20
) (
	input wire logic        ref_clk_i,
	input wire logic        rstn_i,
	input wire logic        sclk_i,
	input wire logic        chip_select_n_i,
	input wire logic        mosi_i,
	input wire logic [15:0] sample_i,
	input wire logic        miso_o,
	input wire logic        miso_oe_o,
	input wire logic        startup_done_o,
	input wire logic [31:0] cmd_o,
	input wire logic        cmd_valid_o
);
	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);
	// saturating count of cycles since reset
	int cyc_r;
	always_ff @(posedge ref_clk_i or negedge rstn_i)
		if (!rstn_i)
			cyc_r <= 0;
		else if (cyc_r < STARTUP_CYCLES)
			cyc_r <= cyc_r + 1;
	oe_release_a: assert property ($rose(chip_select_n_i) |-> ##[1:6] !miso_oe_o) else $error("oe held");
	oe_drive_a: assert property ($fell(chip_select_n_i) |-> ##[1:6] miso_oe_o) else $error("oe late");
	oe_idle_a: assert property (chip_select_n_i [*8] |-> !miso_oe_o) else $error("oe idle");
	frame_end_a: assert property ($rose(chip_select_n_i) |-> ##[1:6] cmd_valid_o) else $error("no update");
	pulse_once_a: assert property (cmd_valid_o |=> !cmd_valid_o) else $error("long pulse");
	cmd_hold_a: assert property ($changed(cmd_o) |-> cmd_valid_o && chip_select_n_i) else $error("cmd moved");
	startup_wait_a: assert property (startup_done_o |-> cyc_r >= STARTUP_CYCLES) else $error("early done");
	edge_only_a: assert property (sclk_i && $past(sclk_i) |-> $stable(miso_o)) else $error("miso moved");
	cover property (cmd_valid_o && startup_done_o);
	cover property ($rose(startup_done_o));
	cover property (miso_oe_o && sclk_i);
endmodule : spi_slave_checks
////////////////////////////////////////
bind inertial_sensor_spi_slave spi_slave_checks #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (.*);

// File: test/inertial_sensor_spi_slave_test.sv
// self-checking bench for the sensor spi slave port
`timescale 1ns/1ps
module inertial_sensor_spi_slave_test;
	logic        ref_clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [15:0] sample_i = 16'h0000;
	logic        sclk, cs_n, mosi, miso_o, miso_oe_o, miso_w, startup_done_o, cmd_valid_o;
	logic        last_r = 1'b0;
	logic [31:0] cmd_o;
	int          fails = 0;
	int          n_compared = 0;
	always #20 ref_clk_i = ~ref_clk_i;
	// released line shows the inverse of its last level
	always @(miso_o or miso_oe_o)
		if (miso_oe_o)
			last_r = miso_o;
	assign miso_w = miso_oe_o ? miso_o : ~last_r;
	spi_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
	inertial_sensor_spi_slave #(.STARTUP_CYCLES(20)) dut (.sclk_i(sclk), .chip_select_n_i(cs_n), .mosi_i(mosi), .*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic t_reset();
		chk({29'h0, miso_oe_o, startup_done_o, cmd_valid_o}, 32'h0);
		chk(cmd_o, 32'h0);
	endtask : t_reset
	// first answer after startup still reports not ready
	task automatic t_chain();
		logic [31:0] r;
		sample_i = 16'h8000;
		repeat (24) @(negedge ref_clk_i);
		host.xfer(32'h1234a5c3, r);
		@(negedge ref_clk_i) sample_i = 16'h7fff;
		host.xfer(32'h00005a00, r);
		chk(r, 32'h0000a500);
		host.xfer(32'hffff0f00, r);
		chk(r, 32'h80005a80);
		host.xfer(32'h8000f0ff, r);
		chk(r, 32'h7fff0f80);
		chk(cmd_o, 32'h8000f0ff);
		chk({31'h0, startup_done_o}, 32'h1);
	endtask : t_chain
	initial
	begin
		repeat (16) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		@(negedge ref_clk_i);
		t_reset();
		t_chain();
		close_out();
	end
	initial
	begin
		#100000;
		fails++;
		close_out();
	end
endmodule : inertial_sensor_spi_slave_test
